// ### verilog/psr_pkg.sv
// shared constants for the single-wire readout link
package psr_pkg;
   localparam int CLK_MHZ = 100;
   // link timing, in its own units
   localparam int SETUP_MIN_US = 25;
   localparam int LOW_PULSE_MIN_NS = 200;
   localparam int HIGH_PULSE_MIN_NS = 200;
   localparam int BIT_SETTLE_MIN_US = 1;
   localparam int END_LOW_MIN_NS = 200;
   // derived cycle counts, least times rounded up
   localparam int SETUP_CYC = SETUP_MIN_US * CLK_MHZ;
   localparam int LOW_CYC = (LOW_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int HIGH_CYC = (HIGH_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int SETTLE_CYC = BIT_SETTLE_MIN_US * CLK_MHZ;
   localparam int END_CYC = (END_LOW_MIN_NS * CLK_MHZ + 999) / 1000;
   // device side: internal conversion ticks
   localparam int CONV_TICKS = 512;
   localparam int UPD_LOW_TICKS = 512;
   localparam int TICK_DIV_DEFAULT = 3125;
   // package layout
   localparam int VAL_W = 14;
   localparam int N_VALS = 3;
   localparam int PKG_BITS = VAL_W * N_VALS;
   localparam logic [13:0] BASELINE = 14'h2008;
   localparam logic [13:0] VAL_MAX = 14'h3fff;
   localparam int CNT_W = 16;
   localparam int BIT_W = 6;
   localparam int SYNC_W = 3;
endpackage : psr_pkg

// ### verilog/psr_link_if.sv
// single-wire link between detector and host
`timescale 1ns/10ps
interface psr_link_if;
   logic dev_out;
   logic dev_oe;
   logic host_out;
   logic host_oe;
   logic line;
   // wired resolution, keeper holds low when nobody drives
   assign line = host_oe ? host_out : (dev_oe ? dev_out : 1'b0);
   modport device (input line, output dev_out, output dev_oe);
   modport host (input line, output host_out, output host_oe);
endinterface : psr_link_if

// ### verilog/psr_device.sv
// detector end: conversion, data-ready and bit shifter
`timescale 1ns/10ps
// Function
// - raise line when new result ready
// - host waits setup before first bit
// - host pulses low then high, releases
// - drive next bit, msb first, after pulse
// - host settles before sampling
// - package is 42 bits
// - host ends package with low pulse
// - update data only after long low
// - host holds high to pause
// - conversion takes 512 ticks, then announce
// - three 14-bit unsigned values per package
// - idle channel rests near baseline
// - host reads up to 64 per second
// - no minimum read rate
// - host masks own edge interrupt
module psr_device #(
   parameter int TICK_DIV = psr_pkg::TICK_DIV_DEFAULT
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // sample source, ch0/ch1 offsets from baseline, temp absolute
   input wire logic [13:0] ch0_in,
   input wire logic [13:0] ch1_in,
   input wire logic [13:0] temp_in,
   // link
   psr_link_if.device link
);
   typedef enum logic [1:0] {D_CONV, D_READY, D_SHIFT} psr_dstate_type;
   typedef struct packed {
      logic [psr_pkg::SYNC_W-1:0] sync;
      logic line_q;
      psr_dstate_type st;
      logic [15:0] div;
      logic [9:0] conv;
      logic [9:0] low_ticks;
      logic [psr_pkg::PKG_BITS-1:0] shreg;
      logic [psr_pkg::PKG_BITS-1:0] result;
      logic fresh;
      logic [psr_pkg::BIT_W-1:0] nsent;
      logic drv;
      logic oe;
   } psr_dev_type;
   psr_dev_type s_reg, s_next;
   logic tick;
   logic line_rise, line_fall;

   // one spare bit so baseline plus offset cannot wrap
   function automatic logic [13:0] clamp(input logic [14:0] v);
      clamp = (v > {1'b0, psr_pkg::VAL_MAX}) ? psr_pkg::VAL_MAX : v[13:0];
   endfunction : clamp

   assign tick = (s_reg.div == 16'(TICK_DIV - 1));
   assign line_rise = (s_reg.sync[2] == s_reg.sync[1]) && s_reg.sync[1]
      && !s_reg.line_q;
   assign line_fall = (s_reg.sync[2] == s_reg.sync[1]) && !s_reg.sync[1]
      && s_reg.line_q;

   always_comb begin
      s_next = s_reg;
      s_next.sync = {s_reg.sync[1:0], link.line};
      if (s_reg.sync[2] == s_reg.sync[1]) begin
         s_next.line_q = s_reg.sync[1];
      end
      s_next.div = tick ? 16'h0000 : s_reg.div + 16'h0001;
      // conversion runs free on the internal tick
      if (tick) begin
         if (s_reg.conv == 10'(psr_pkg::CONV_TICKS - 1)) begin
            s_next.conv = 10'h000;
            // ch0 and ch1 offset from baseline; temperature as is
            s_next.result = {
               clamp({1'b0, psr_pkg::BASELINE} + {1'b0, ch0_in}),
               clamp({1'b0, psr_pkg::BASELINE} + {1'b0, ch1_in}),
               clamp({1'b0, temp_in})};
            s_next.fresh = 1'b1;
         end else begin
            s_next.conv = s_reg.conv + 10'h001;
         end
         if (!s_reg.line_q && s_reg.low_ticks != 10'h3ff) begin
            s_next.low_ticks = s_reg.low_ticks + 10'h001;
         end
      end
      if (s_reg.line_q) begin
         s_next.low_ticks = 10'h000;
      end
      case (s_reg.st)
         D_CONV: begin
            s_next.oe = 1'b0;
            // load only after a long low; never while high
            if (s_reg.fresh && !s_reg.line_q
                && s_reg.low_ticks > 10'(psr_pkg::UPD_LOW_TICKS)) begin
               s_next.shreg = s_next.fresh ? s_next.result : s_reg.result;
               s_next.fresh = 1'b0;
               s_next.st = D_READY;
               s_next.drv = 1'b1;
               s_next.oe = 1'b1;
            end
         end
         D_READY: begin
            // host's low pulse takes over from data-ready
            if (line_fall) begin
               s_next.oe = 1'b0;
               s_next.nsent = '0;
               s_next.st = D_SHIFT;
            end
         end
         D_SHIFT: begin
            // host pulse or a driven zero; either way let go
            if (line_fall) begin
               s_next.oe = 1'b0;
               if (s_reg.nsent == 6'(psr_pkg::PKG_BITS)) begin
                  s_next.st = D_CONV;
               end
            end
            if (line_rise) begin
               // drive msb from the rise of the host's high; it shows on release
               s_next.drv = s_reg.shreg[psr_pkg::PKG_BITS-1];
               s_next.shreg = {s_reg.shreg[psr_pkg::PKG_BITS-2:0], 1'b0};
               s_next.oe = 1'b1;
               s_next.nsent = s_reg.nsent + 6'h01;
            end
         end
         default: s_next.st = D_CONV;
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign link.dev_out = s_reg.drv;
   assign link.dev_oe = s_reg.oe;
endmodule : psr_device

// ### verilog/psr_host.sv
// host end: waits for data-ready and clocks out one package
`timescale 1ns/10ps
module psr_host (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // user side
   input wire logic pause_in,
   output logic [psr_pkg::PKG_BITS-1:0] data_out,
   output logic data_valid_out,
   input wire logic data_ready_in,
   output logic busy_out,
   // link
   psr_link_if.host link
);
   typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_SETTLE,
      H_PAUSE, H_END, H_FLUSH} psr_hstate_type;
   typedef struct packed {
      logic [psr_pkg::SYNC_W-1:0] sync;
      logic line_q;
      psr_hstate_type st;
      logic [psr_pkg::CNT_W-1:0] cnt;
      logic [psr_pkg::BIT_W-1:0] nbit;
      logic [psr_pkg::PKG_BITS-1:0] sh;
      logic drv;
      logic oe;
      logic [1:0] fv;
      logic [psr_pkg::PKG_BITS-1:0] f0;
      logic [psr_pkg::PKG_BITS-1:0] f1;
   } psr_host_type;
   psr_host_type s_reg, s_next;
   logic push, pop, fifo_ready;

   assign fifo_ready = !s_reg.fv[1];
   assign pop = s_reg.fv[0] && data_ready_in;
   assign push = (s_reg.st == H_FLUSH) && fifo_ready;

   always_comb begin
      s_next = s_reg;
      s_next.sync = {s_reg.sync[1:0], link.line};
      if (s_reg.sync[2] == s_reg.sync[1]) begin
         s_next.line_q = s_reg.sync[1];
      end
      s_next.cnt = s_reg.cnt + 16'h0001;
      case (s_reg.st)
         H_IDLE: begin
            // any rate is fine; read starts only on data-ready
            s_next.oe = 1'b0;
            s_next.cnt = '0;
            if (s_reg.line_q && fifo_ready) begin
               s_next.st = H_SETUP;
            end
         end
         H_SETUP: begin
            if (s_reg.cnt >= 16'(psr_pkg::SETUP_CYC)) begin
               s_next.st = H_LOW;
               s_next.cnt = '0;
               s_next.drv = 1'b0;
               s_next.oe = 1'b1;
            end
         end
         H_LOW: begin
            if (s_reg.cnt >= 16'(psr_pkg::LOW_CYC - 1)) begin
               s_next.st = H_HIGH;
               s_next.cnt = '0;
               s_next.drv = 1'b1;
            end
         end
         H_HIGH: begin
            if (s_reg.cnt >= 16'(psr_pkg::HIGH_CYC - 1)) begin
               s_next.cnt = '0;
               if (pause_in) begin
                  // stretched high doubles as the pause
                  s_next.st = H_PAUSE;
               end else begin
                  s_next.st = H_SETTLE;
                  s_next.oe = 1'b0;
               end
            end
         end
         H_SETTLE: begin
            // settle covers the sync delay too
            if (s_reg.cnt >= 16'(psr_pkg::SETTLE_CYC + psr_pkg::SYNC_W))
            begin
               s_next.sh = {s_reg.sh[psr_pkg::PKG_BITS-2:0], s_reg.line_q};
               s_next.nbit = s_reg.nbit + 6'h01;
               s_next.cnt = '0;
               s_next.drv = 1'b0;
               s_next.oe = 1'b1;
               if (s_reg.nbit == 6'(psr_pkg::PKG_BITS - 1)) begin
                  s_next.st = H_END;
               end else begin
                  s_next.st = H_LOW;
               end
            end
         end
         H_PAUSE: begin
            // line held high freezes the device data
            s_next.cnt = '0;
            if (!pause_in) begin
               s_next.oe = 1'b0;
               s_next.st = H_SETTLE;
            end
         end
         H_END: begin
            if (s_reg.cnt >= 16'(psr_pkg::END_CYC - 1)) begin
               s_next.oe = 1'b0;
               s_next.nbit = '0;
               s_next.st = H_FLUSH;
            end
         end
         H_FLUSH: begin
            if (push) begin
               s_next.st = H_IDLE;
               s_next.cnt = '0;
            end
         end
         default: s_next.st = H_IDLE;
      endcase
      // two-entry buffer, f0 is head
      if (pop) begin
         s_next.f0 = s_reg.f1;
         s_next.fv = {1'b0, s_reg.fv[1]};
      end
      if (push) begin
         if (s_next.fv[0]) begin
            s_next.f1 = s_reg.sh;
            s_next.fv[1] = 1'b1;
         end else begin
            s_next.f0 = s_reg.sh;
            s_next.fv[0] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign link.host_out = s_reg.drv;
   assign link.host_oe = s_reg.oe;
   assign data_out = s_reg.f0;
   assign data_valid_out = s_reg.fv[0];
   assign busy_out = (s_reg.st != H_IDLE);
endmodule : psr_host

// ### dv/psr_link_checker.sv
// assertions on the shared readout line
`timescale 1ns/10ps
module psr_link_checker #(
   parameter int TICK_DIV = psr_pkg::TICK_DIV_DEFAULT
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // link signals
   input wire logic dev_out,
   input wire logic dev_oe,
   input wire logic host_out,
   input wire logic host_oe,
   input wire logic line
);
   logic hlo;
   logic hhi;
   logic [15:0] hlo_reg, hhi_reg, rel_reg, up_reg, dn_reg;
   logic [5:0] bit_reg;
   assign hlo = host_oe && !host_out;
   assign hhi = host_oe && host_out;
   // run lengths, read at the edge where the run ends
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hlo_reg <= 16'h0;
         hhi_reg <= 16'h0;
         rel_reg <= 16'h0;
         up_reg <= 16'h0;
         dn_reg <= 16'h0;
         bit_reg <= 6'h0;
      end else begin
         hlo_reg <= hlo ? hlo_reg + 16'h1 : 16'h0;
         hhi_reg <= hhi ? hhi_reg + 16'h1 : 16'h0;
         rel_reg <= host_oe ? 16'h0 : rel_reg + 16'h1;
         up_reg <= (line && !host_oe) ? up_reg + 16'h1 : 16'h0;
         dn_reg <= line ? 16'h0 : dn_reg + 16'h1;
         // 43 low pulses a package, the last one closes it
         if (hlo && hlo_reg == 16'h0)
            bit_reg <= bit_reg + 6'h1;
         else if (!hlo && hlo_reg != 16'h0 && bit_reg == 6'h2b)
            bit_reg <= 6'h0;
      end
   end
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   low_pulse_min_a:
      assert property ($fell(hlo) |-> hlo_reg >= 16'(psr_pkg::LOW_CYC))
      else $error("host low pulse too short");
   high_pulse_min_a:
      assert property ($fell(hhi) |-> hhi_reg >= 16'(psr_pkg::HIGH_CYC))
      else $error("host high pulse too short");
   bit_pulse_a:
      assert property ($fell(hlo) && bit_reg != 6'h2b |-> hhi)
      else $error("low pulse not followed by high");
   package_end_a:
      assert property ($fell(hlo) && bit_reg == 6'h2b |-> !host_oe)
      else $error("closing pulse not released");
   setup_wait_a:
      assert property ($rose(host_oe) && bit_reg == 6'h0
         |-> up_reg >= 16'(psr_pkg::SETUP_CYC))
      else $error("first bit before setup time");
   settle_wait_a:
      assert property ($rose(host_oe) && bit_reg != 6'h0
         |-> rel_reg >= 16'(psr_pkg::SETTLE_CYC))
      else $error("bit sampled before settling");
   ready_hold_a:
      assert property (bit_reg == 6'h0 && !host_oe && line
         |=> line || host_oe)
      else $error("data ready dropped before read");
   update_gap_a:
      assert property ($rose(line) && !host_oe && bit_reg == 6'h0
         |-> dn_reg >= 16'((psr_pkg::UPD_LOW_TICKS - 1) * TICK_DIV))
      else $error("announce without long low");
   bit_drive_a:
      assert property ($fell(host_oe) && bit_reg != 6'h0
         && bit_reg != 6'h2b |-> dev_oe)
      else $error("device not driving its bit");
endmodule : psr_link_checker

// ### dv/pyro_single_wire_readout_bench.sv
// bench joining detector and host ends over the link
`timescale 1ns/10ps
module pyro_single_wire_readout_bench;
   localparam int TDIV = 4;
   localparam logic [13:0] BL = psr_pkg::BASELINE;
   logic clk_sys_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [13:0] ch0 = 14'h0;
   logic [13:0] ch1 = 14'h0;
   logic [13:0] tmp = 14'h1234;
   logic pause = 1'b0;
   logic rdy = 1'b0;
   logic [41:0] data;
   logic valid;
   logic busy;
   logic [41:0] w;
   int err_total = 0;
   int samples_checked = 0;
   psr_link_if link ();
   psr_device #(.TICK_DIV(TDIV)) i_psr_device (.clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in), .ch0_in(ch0), .ch1_in(ch1), .temp_in(tmp),
      .link(link.device));
   psr_host i_psr_host (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .pause_in(pause), .data_out(data), .data_valid_out(valid),
      .data_ready_in(rdy), .busy_out(busy), .link(link.host));
   psr_link_checker #(.TICK_DIV(TDIV)) i_psr_link_checker (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .dev_out(link.dev_out),
      .dev_oe(link.dev_oe), .host_out(link.host_out),
      .host_oe(link.host_oe), .line(link.line));
   always #5 clk_sys_in = ~clk_sys_in;
   task automatic check(string what, logic [41:0] seen, logic [41:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic end_sim();
      $display("mismatches %0d checks %0d", err_total, samples_checked);
      if (err_total == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   // bounded wait; a word that never comes shows up as a mismatch
   task automatic wait_word();
      repeat (20000) begin
         @(negedge clk_sys_in);
         if (valid === 1'b1) break;
      end
      check("word valid", {41'h0, valid}, 42'h1);
      w = data;
   endtask : wait_word
   task automatic pop();
      @(posedge clk_sys_in);
      rdy <= 1'b1;
      @(posedge clk_sys_in);
      rdy <= 1'b0;
   endtask : pop
   task automatic t_baseline();
      wait_word();
      check("baseline word", w, {BL, BL, 14'h1234});
      pop();
   endtask : t_baseline
   task automatic t_clamp();
      ch0 <= 14'h1fff;
      ch1 <= 14'h0005;
      tmp <= 14'h3fff;
      // first word may predate the change
      wait_word();
      pop();
      wait_word();
      check("clamped word", w, {14'h3fff, BL + 14'h5, 14'h3fff});
      pop();
   endtask : t_clamp
   task automatic t_pause();
      repeat (20000) begin
         @(negedge clk_sys_in);
         if (busy === 1'b1) break;
      end
      repeat (3500) @(negedge clk_sys_in);
      @(posedge clk_sys_in);
      pause <= 1'b1;
      ch0 <= 14'h0;
      ch1 <= 14'h0;
      tmp <= 14'h0abc;
      repeat (3000) @(negedge clk_sys_in);
      check("paused line", {41'h0, link.line}, 42'h1);
      @(posedge clk_sys_in);
      pause <= 1'b0;
      wait_word();
      check("paused word", w, {14'h3fff, BL + 14'h5, 14'h3fff});
      pop();
   endtask : t_pause
   task automatic t_full();
      wait_word();
      check("first held word", w, {BL, BL, 14'h0abc});
      // no pops: second word fills the buffer, third is refused
      repeat (16000) @(negedge clk_sys_in);
      check("refused ready line", {41'h0, link.line}, 42'h1);
      check("refused busy", {41'h0, busy}, 42'h0);
      pop();
      wait_word();
      check("second held word", w, {BL, BL, 14'h0abc});
      pop();
      @(negedge clk_sys_in);
      check("buffer empty", {41'h0, valid}, 42'h0);
   endtask : t_full
   initial begin
      repeat (100000) @(posedge clk_sys_in);
      err_total++;
      end_sim();
   end
   initial begin
      repeat (8) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      t_baseline();
      t_clamp();
      t_pause();
      t_full();
      end_sim();
   end
endmodule : pyro_single_wire_readout_bench
